// file: idle_pm_pkg.sv
// Package with register map, reset values and timing constants of the idle power state manager.
// Behaviour
// R1 - Modes: disabled default, fixed defaults, user defined.
// R2 - Enabled activity restarts standby timer at full speed.
// R3 - Standby expiry slows CPU, blanks display. Code blanks it only in fixed mode or with the video bit set.
// R4 - Standby timeout: off,7s,30s,3.8m,7m,14.5m,58m,240m.
// R5 - In standby, watch suspend event enables.
// R6 - Suspend timer from standby entry; expiry stops CPU.
// R7 - Suspend timeout: off,14s,56s,3.8m,7m,58m,240m.
// R8 - Any event wakes fully and restarts standby timer. The code wakes only on suspend-enabled events and video refresh.
// R9 - Video option blanks display after standby period.
// R10 - Disk idle timer 1-15 min, wakes on access.
// R11 - Enabled events block and end power saving.
// R12 - Keyboard, serial, printer accesses individually enabled.
// R13 - Bus master or DMA requests count when enabled.
// R14 - Disk, off-board memory, local master individually enabled.
// R15 - Video refresh activity always counts.
// R16 - I/O block detector, off or 300H-3E0H.
// R17 - Disabled timeout never expires.
package idle_pm_pkg;

  // Register word offsets.
  localparam logic [3:0] OFF_MODE      = 4'h0;
  localparam logic [3:0] OFF_STBY_TIME = 4'h1;
  localparam logic [3:0] OFF_SUSP_TIME = 4'h2;
  localparam logic [3:0] OFF_HDD_TIME  = 4'h3;
  localparam logic [3:0] OFF_STBY_EN   = 4'h4;
  localparam logic [3:0] OFF_SUSP_EN   = 4'h5;
  localparam logic [3:0] OFF_IO_RANGE  = 4'h6;
  localparam logic [3:0] OFF_STATE     = 4'h7;
  localparam logic [3:0] OFF_INT_STAT  = 4'h8;
  localparam logic [3:0] OFF_INT_MASK  = 4'h9;

  // Operating selections.
  localparam logic [1:0] MODE_OFF   = 2'h0;
  localparam logic [1:0] MODE_FIXED = 2'h1;
  localparam logic [1:0] MODE_USER  = 2'h2;
  localparam int         MODE_VIDEO_BIT = 2;

  // Event enable bit positions.
  localparam int EV_KBD = 0;
  localparam int EV_SER = 1;
  localparam int EV_PAR = 2;
  localparam int EV_HDD = 3;
  localparam int EV_DMA = 4;
  localparam int EV_MEM = 5;
  localparam int EV_IO  = 6;
  localparam int EV_LBM = 7;

  // Interrupt status bit positions.
  localparam int IRQ_STBY = 0;
  localparam int IRQ_SUSP = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_HDD  = 3;

  // Reset values and fixed defaults used by the fixed selection.
  localparam logic [2:0] RST_MODE        = 3'h0;
  localparam logic [2:0] RST_STBY_TIME   = 3'h0;
  localparam logic [2:0] RST_SUSP_TIME   = 3'h0;
  localparam logic [3:0] RST_HDD_TIME    = 4'h0;
  localparam logic [7:0] RST_EV_EN       = 8'h00;
  localparam logic [3:0] RST_IO_RANGE    = 4'h0;
  localparam logic [3:0] RST_INT_MASK    = 4'h0;
  localparam logic [2:0] FIX_STBY_TIME   = 3'h3;
  localparam logic [2:0] FIX_SUSP_TIME   = 3'h3;
  localparam logic [3:0] FIX_HDD_TIME    = 4'h5;
  localparam logic [7:0] FIX_EV_EN       = 8'hBF;

  // Timeouts in seconds.
  localparam logic [15:0] STBY_SEC [8] = '{16'h0000, 16'h0007, 16'h001E, 16'h00E4,
                                           16'h01A4, 16'h0366, 16'h0D98, 16'h3840};
  localparam logic [15:0] SUSP_SEC [8] = '{16'h0000, 16'h000E, 16'h0038, 16'h00E4,
                                           16'h01A4, 16'h0D98, 16'h3840, 16'h0000};
  localparam logic [15:0] HDD_STEP_SEC = 16'h003C;

  // I/O detector: 16-address blocks from this base upward.
  localparam logic [5:0] IO_BASE_BLOCK = 6'h30;

  // Timebase: one tick per second at 25 MHz.
  localparam int TICK_TIME_MS    = 1000;
  localparam int CLK_KHZ         = 25000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_MS * CLK_KHZ;

  typedef enum logic [2:0] {
    ST_FULL    = 3'b001,
    ST_STANDBY = 3'b010,
    ST_SUSPEND = 3'b100
  } pm_state_t;

endpackage

// file: idle_power_state_manager.sv
// Inactivity-driven standby and suspend controller with disk idle timer.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
module idle_power_state_manager #(
  parameter int TICK_CYCLES = idle_pm_pkg::TICK_CYCLES_DEF
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rd_data,
  // Activity sources
  input  wire logic       kbd_access,
  input  wire logic       serial_access,
  input  wire logic       parallel_access,
  input  wire logic       hdd_access,
  input  wire logic       dma_master_req,
  input  wire logic       offboard_mem_access,
  input  wire logic       video_refresh,
  input  wire logic       io_access,
  input  wire logic [9:0] io_addr,
  input  wire logic       local_master_access,
  // Power controls
  output logic            cpu_slow,
  output logic            cpu_stop,
  output logic            power_down,
  output logic            display_off,
  output logic            hdd_power_off,
  output logic            irq
);
  import idle_pm_pkg::*;

  logic [2:0]  mode_reg;
  logic [2:0]  stby_time_reg;
  logic [2:0]  susp_time_reg;
  logic [3:0]  hdd_time_reg;
  logic [7:0]  stby_en_reg;
  logic [7:0]  susp_en_reg;
  logic [3:0]  io_range_reg;
  logic [3:0]  int_stat_reg;
  logic [3:0]  int_mask_reg;
  pm_state_t   state_reg;
  pm_state_t   state_next;
  logic [24:0] prescale_reg;
  logic [15:0] idle_sec_reg;
  logic [15:0] hdd_sec_reg;
  logic        tick;
  logic        pm_on;
  logic        video_ctl;
  logic [2:0]  eff_stby;
  logic [2:0]  eff_susp;
  logic [3:0]  eff_hdd;
  logic [7:0]  eff_stby_en;
  logic [7:0]  eff_susp_en;
  logic [7:0]  sources;
  logic        activity;
  logic        expire;
  logic [15:0] limit;
  logic [15:0] hdd_limit;
  logic [3:0]  irq_events;
  logic        stat_read;
  logic [3:0]  int_stat_next;
  logic        hdd_expire;

  // Base decoder of the selectable 16-address block; zero selects none.
  function automatic logic io_hit(input logic [3:0] sel, input logic [9:0] a);
    io_hit = (sel != 4'h0) && (a[9:4] == IO_BASE_BLOCK + {2'h0, sel} - 6'h01);
  endfunction

  // True when the fixed selection replaces the user settings.
  function automatic logic is_fixed(input logic [2:0] m);
    is_fixed = (m[1:0] == MODE_FIXED);
  endfunction

  // True for a write strobe aimed at one register word.
  function automatic logic wr_hit(input logic s, input logic [3:0] a, input logic [3:0] off);
    wr_hit = s && (a == off);
  endfunction

  // Refresh activity bypasses the enables, so it can never be masked.
  function automatic logic ev_hit(input logic [7:0] src, input logic [7:0] en, input logic refresh);
    ev_hit = (|(src & en)) | refresh;
  endfunction

  // Fixed selection overrides the user settings with built-in defaults.
  always_comb begin
    pm_on       = (mode_reg[1:0] != MODE_OFF); // R1
    video_ctl   = is_fixed(mode_reg) | mode_reg[MODE_VIDEO_BIT];
    eff_stby    = is_fixed(mode_reg) ? FIX_STBY_TIME : stby_time_reg; // R1
    eff_susp    = is_fixed(mode_reg) ? FIX_SUSP_TIME : susp_time_reg;
    eff_hdd     = is_fixed(mode_reg) ? FIX_HDD_TIME : hdd_time_reg;
  end

  always_comb begin
    eff_stby_en = is_fixed(mode_reg) ? FIX_EV_EN : stby_en_reg;
    eff_susp_en = is_fixed(mode_reg) ? FIX_EV_EN : susp_en_reg;
  end

  // The I/O strobe counts only when its address falls in the selected block.
  always_comb begin
    sources         = 8'h00;
    sources[EV_KBD] = kbd_access; // R12
    sources[EV_SER] = serial_access; // R12
    sources[EV_PAR] = parallel_access; // R12
    sources[EV_HDD] = hdd_access; // R14
    sources[EV_DMA] = dma_master_req; // R13
    sources[EV_MEM] = offboard_mem_access; // R14
    sources[EV_IO]  = io_access & io_hit(io_range_reg, io_addr); // R16
    sources[EV_LBM] = local_master_access; // R14
  end

  // The suspend enables take over once the system has left full speed.
  always_comb begin
    if (state_reg == ST_FULL) begin
      activity = ev_hit(sources, eff_stby_en, video_refresh); // R2 R15
    end else begin
      activity = ev_hit(sources, eff_susp_en, video_refresh); // R5 R15
    end
  end

  always_comb begin
    limit = (state_reg == ST_FULL) ? STBY_SEC[eff_stby] : SUSP_SEC[eff_susp]; // R4 R7
  end

  // The idle counters saturate, so a long quiet spell never wraps back below a limit.
  always_comb begin
    expire = pm_on && (limit != 16'h0000) && (idle_sec_reg >= limit) && !activity; // R17 R11
  end

  always_comb begin
    hdd_limit = 16'({12'h000, eff_hdd} * HDD_STEP_SEC); // R10
  end

  // Disk expiry is decoded once for both the power control and its status bit.
  always_comb begin
    hdd_expire = pm_on && (eff_hdd != 4'h0) && !hdd_access && (hdd_sec_reg >= hdd_limit); // R10 R17
  end

  // One-second timebase, restarted by activity so a timeout counted from activity is never short.
  always_comb begin
    tick = (prescale_reg == 25'(TICK_CYCLES - 1));
  end

  always_ff @(posedge core_clk) begin
    if (rst || activity || tick) begin
      prescale_reg <= '0;
    end else begin
      prescale_reg <= prescale_reg + 25'h0000001;
    end
  end

  // Turning the mode off forces full speed, so no saving state outlives the disabled selection.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_FULL: begin
        if (expire) begin
          state_next = ST_STANDBY; // R3
        end
      end
      ST_STANDBY: begin
        if (activity) begin
          state_next = ST_FULL; // R8 R11
        end else if (expire) begin
          state_next = ST_SUSPEND; // R6
        end
      end
      ST_SUSPEND: begin
        if (activity) begin
          state_next = ST_FULL; // R8 R11
        end
      end
      default: state_next = ST_FULL;
    endcase
    if (!pm_on) begin
      state_next = ST_FULL; // R1
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_FULL;
    end else begin
      state_reg <= state_next;
    end
  end

  // Idle seconds restart on activity and on every state change.
  always_ff @(posedge core_clk) begin
    if (rst || activity || state_next != state_reg || !pm_on) begin
      idle_sec_reg <= '0; // R2 R6 R8
    end else if (tick && idle_sec_reg != 16'hFFFF) begin
      idle_sec_reg <= idle_sec_reg + 16'h0001;
    end
  end

  // Disk idle timer runs apart from the system state.
  always_ff @(posedge core_clk) begin
    if (rst || hdd_access || !pm_on) begin
      hdd_sec_reg <= '0; // R10
    end else if (tick && hdd_sec_reg != 16'hFFFF) begin
      hdd_sec_reg <= hdd_sec_reg + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hdd_power_off <= 1'b0;
    end else if (hdd_access || !pm_on || eff_hdd == 4'h0) begin
      hdd_power_off <= 1'b0; // R10 R17
    end else if (hdd_expire) begin
      hdd_power_off <= 1'b1; // R10
    end
  end

  // cpu_slow, cpu_stop, power_down and display_off are registered from the next state, so each moves together with the state.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_slow <= 1'b0;
    end else begin
      cpu_slow <= (state_next == ST_STANDBY); // R3
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cpu_stop <= 1'b0;
    end else begin
      cpu_stop <= (state_next == ST_SUSPEND); // R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= (state_next == ST_SUSPEND); // R6
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      display_off <= 1'b0;
    end else begin
      display_off <= (state_next != ST_FULL) && video_ctl; // R3 R9
    end
  end

  always_comb begin
    irq_events           = 4'h0;
    irq_events[IRQ_STBY] = (state_reg == ST_FULL) && (state_next == ST_STANDBY);
    irq_events[IRQ_SUSP] = (state_reg == ST_STANDBY) && (state_next == ST_SUSPEND);
    irq_events[IRQ_WAKE] = (state_reg != ST_FULL) && (state_next == ST_FULL);
    irq_events[IRQ_HDD]  = !hdd_power_off && hdd_expire;
  end

  always_comb begin
    stat_read = rd_stb && (addr == OFF_INT_STAT);
  end

  // A read clears the status, but an event in that same cycle survives it.
  always_comb begin
    int_stat_next = stat_read ? irq_events : (int_stat_reg | irq_events);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_stat_reg <= '0;
    end else begin
      int_stat_reg <= int_stat_next;
    end
  end

  // The interrupt follows the next status, so it rises in the same cycle as its status bit.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_mask_reg & int_stat_next);
    end
  end

  // Each configuration word has its own write decode; writes to other words are ignored.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg <= RST_MODE;
    end else if (wr_hit(wr_stb, addr, OFF_MODE)) begin
      mode_reg <= wr_data[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stby_time_reg <= RST_STBY_TIME;
    end else if (wr_hit(wr_stb, addr, OFF_STBY_TIME)) begin
      stby_time_reg <= wr_data[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      susp_time_reg <= RST_SUSP_TIME;
    end else if (wr_hit(wr_stb, addr, OFF_SUSP_TIME)) begin
      susp_time_reg <= wr_data[2:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hdd_time_reg <= RST_HDD_TIME;
    end else if (wr_hit(wr_stb, addr, OFF_HDD_TIME)) begin
      hdd_time_reg <= wr_data[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      stby_en_reg <= RST_EV_EN;
    end else if (wr_hit(wr_stb, addr, OFF_STBY_EN)) begin
      stby_en_reg <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      susp_en_reg <= RST_EV_EN;
    end else if (wr_hit(wr_stb, addr, OFF_SUSP_EN)) begin
      susp_en_reg <= wr_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      io_range_reg <= RST_IO_RANGE;
    end else if (wr_hit(wr_stb, addr, OFF_IO_RANGE)) begin
      io_range_reg <= wr_data[3:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_mask_reg <= RST_INT_MASK;
    end else if (wr_hit(wr_stb, addr, OFF_INT_MASK)) begin
      int_mask_reg <= wr_data[3:0];
    end
  end

  // Unmapped words read as zero, as do the unused high bits of every word.
  function automatic logic [7:0] read_word(input logic [3:0] a);
    case (a)
      OFF_MODE:      read_word = {5'h00, mode_reg};
      OFF_STBY_TIME: read_word = {5'h00, stby_time_reg};
      OFF_SUSP_TIME: read_word = {5'h00, susp_time_reg};
      OFF_HDD_TIME:  read_word = {4'h0, hdd_time_reg};
      OFF_STBY_EN:   read_word = stby_en_reg;
      OFF_SUSP_EN:   read_word = susp_en_reg;
      OFF_IO_RANGE:  read_word = {4'h0, io_range_reg};
      OFF_STATE:     read_word = {4'h0, hdd_power_off, state_reg};
      OFF_INT_STAT:  read_word = {4'h0, int_stat_reg};
      OFF_INT_MASK:  read_word = {4'h0, int_mask_reg};
      default:       read_word = 8'h00;
    endcase
  endfunction

  // Read data is valid only in the cycle after the strobe; it is zero otherwise.
  always_ff @(posedge core_clk) begin
    if (rst || !rd_stb) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= read_word(addr);
    end
  end

endmodule

// file: idle_pm_props.sv
// Concurrent checks on the power controls and read port of the idle power state manager.
`timescale 1ns/100ps
module idle_pm_props (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // Observed ports
  input wire logic       rd_stb,
  input wire logic [7:0] rd_data,
  input wire logic       video_refresh,
  input wire logic       hdd_access,
  input wire logic       cpu_slow,
  input wire logic       cpu_stop,
  input wire logic       power_down,
  input wire logic       display_off,
  input wire logic       hdd_power_off
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_STOP_POWER: assert property (cpu_stop == power_down) else $error("stop and power down differ");
  AST_RD_IDLE: assert property (!rd_stb |=> rd_data == 8'h00) else $error("read data outside slot");
  AST_WAKE: assert property (video_refresh |=> !cpu_slow && !cpu_stop && !display_off)
    else $error("refresh did not wake");
  AST_HDD_WAKE: assert property (hdd_access |=> !hdd_power_off) else $error("disk stayed off");
  AST_SUSP_ORDER: assert property ($rose(cpu_stop) |-> $past(cpu_slow)) else $error("suspend skipped standby");
  AST_STBY_ORDER: assert property ($rose(cpu_slow) |-> !$past(cpu_stop)) else $error("standby from suspend");
  AST_IDLE_GATE: assert property (($rose(cpu_slow) || $rose(cpu_stop)) |-> !$past(video_refresh))
    else $error("saving entered during activity");
  AST_DISPLAY: assert property (display_off |-> cpu_slow || cpu_stop) else $error("display off at full power");
  COV_STBY: cover property ($rose(cpu_slow));
  COV_SUSP: cover property ($rose(cpu_stop));
  COV_DISK: cover property ($rose(hdd_power_off));
endmodule
bind idle_power_state_manager idle_pm_props u_props (.core_clk(core_clk), .rst(rst), .rd_stb(rd_stb),
  .rd_data(rd_data), .video_refresh(video_refresh), .hdd_access(hdd_access), .cpu_slow(cpu_slow),
  .cpu_stop(cpu_stop), .power_down(power_down), .display_off(display_off), .hdd_power_off(hdd_power_off));

// file: activity_source_model.sv
// Model of the peripherals whose accesses count as activity.
`timescale 1ns/100ps
module activity_source_model (
  // Clock
  input  wire logic       core_clk,
  // Bench command
  input  wire logic       fire,
  input  wire logic [3:0] src,
  input  wire logic [9:0] port,
  // Activity outputs
  output logic      [8:0] act,
  output logic      [9:0] io_addr
);
  // Accesses are one-cycle pulses; an idle address bus shows the inverse so stale hits cannot pass.
  always_ff @(posedge core_clk) begin
    act     <= fire ? (9'h001 << src) : 9'h000;
    io_addr <= fire ? port : ~port;
  end
endmodule

// file: test_idle_power_state_manager.sv
// Self-checking testbench for the idle power state manager.
`timescale 1ns/100ps
module test_idle_power_state_manager;
  import idle_pm_pkg::*;
  localparam int T = 10;
  logic       core_clk, rst, wr_stb, rd_stb, fire;
  logic [3:0] addr, src;
  logic [7:0] wr_data, rd_data, v;
  logic [9:0] port, io_addr;
  logic [8:0] act;
  logic [2:0] pwr;
  logic       cpu_slow, cpu_stop, power_down, display_off, hdd_power_off, irq;
  int         error_cnt, tests_run, sel, k;
  int         exp_reg[16];
  int         wmask[16] = '{7, 7, 7, 15, 255, 255, 15, 0, 0, 15, 0, 0, 0, 0, 0, 0};
  int         srcq[$];
  assign pwr = {hdd_power_off, cpu_stop, cpu_slow};
  idle_power_state_manager #(.TICK_CYCLES(T)) DUT (.core_clk(core_clk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .kbd_access(act[0]),
    .serial_access(act[1]), .parallel_access(act[2]), .hdd_access(act[3]), .dma_master_req(act[4]),
    .offboard_mem_access(act[5]), .io_access(act[6]), .local_master_access(act[7]), .video_refresh(act[8]),
    .io_addr(io_addr), .cpu_slow(cpu_slow), .cpu_stop(cpu_stop), .power_down(power_down),
    .display_off(display_off), .hdd_power_off(hdd_power_off), .irq(irq));
  activity_source_model PEER (.core_clk(core_clk), .fire(fire), .src(src), .port(port), .act(act),
    .io_addr(io_addr));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rng(input string n, input int lo, input int hi, input int g);
    tests_run++;
    if (g < lo || g > hi) begin
      error_cnt++;
      $display("BAD %s expected %0d..%0d seen %0d", n, lo, hi, g);
    end
  endtask
  task automatic wr(input int a, input int d);
    @(posedge core_clk);
    addr <= 4'(a);
    wr_data <= 8'(d);
    wr_stb <= 1'h1;
    if (a != 7 && a != 8) exp_reg[a] = d & wmask[a];
    @(posedge core_clk);
    wr_stb <= 1'h0;
  endtask
  task automatic rd(input int a);
    @(posedge core_clk);
    addr <= 4'(a);
    rd_stb <= 1'h1;
    @(posedge core_clk);
    rd_stb <= 1'h0;
    #1 v = rd_data;
  endtask
  task automatic pulse(input int n);
    @(posedge core_clk);
    src <= 4'(n);
    port <= {6'(IO_BASE_BLOCK + sel - 1), 4'($urandom)};
    fire <= 1'h1;
    @(posedge core_clk);
    fire <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask
  // Bounded wait on one power output; a late or early change shows as a count outside the window.
  task automatic wait_on(input string n, input int b, input int lo, input int hi);
    int c;
    c = 0;
    while (pwr[b] !== 1'h1 && c < hi) begin
      @(posedge core_clk);
      c++;
    end
    chk_rng(n, lo, hi - 1, c);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'h0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #(40 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst = 1'h1;
    {wr_stb, rd_stb, fire, addr, src, wr_data, port} = '0;
    sel = 1;
    void'($urandom(32'h24467AEC));
    foreach (exp_reg[i]) exp_reg[i] = 0;
    exp_reg[7] = 1;
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    for (int a = 0; a < 16; a++) begin
      rd(a);
      chk("reset value", 8'(exp_reg[a]), v);
    end
    // Mode stays off here, so random timer settings cannot move the state mid-check.
    for (int a = 1; a < 16; a++) wr(a, $urandom);
    for (int a = 0; a < 16; a++) begin
      rd(a);
      chk("readback", 8'(exp_reg[a]), v);
    end
    wr(1, 1);
    repeat (20 * T) @(posedge core_clk);
    rd(7);
    chk("off mode state", 8'h01, v);
    wr(0, 1);
    wait_on("fixed standby", 0, 227 * T - 5, 229 * T + 5);
    chk("fixed display", 8'h01, 8'(display_off));
    pulse(8);
    chk("refresh wake", 8'h00, 8'(pwr));
    wr(0, 6);
    wr(2, 1);
    wr(3, 0);
    wr(4, 255);
    wr(5, 255);
    sel = 1 + $urandom % 15;
    wr(6, sel);
    wr(9, 15);
    rd(8);
    pulse(0);
    repeat (4 * T) @(posedge core_clk);
    pulse(1);
    wait_on("standby", 0, 6 * T - 5, 8 * T + 5);
    chk("display", 8'h01, 8'(display_off));
    chk("irq", 8'h01, 8'(irq));
    rd(8);
    chk("status", 8'h01, v);
    repeat (2) @(posedge core_clk);
    chk("irq clear", 8'h00, 8'(irq));
    wait_on("suspend", 1, 13 * T - 5, 15 * T + 5);
    chk("power down", 8'h01, 8'(power_down));
    for (int i = 0; i < 8; i++) srcq.push_back(i);
    srcq.shuffle();
    while (srcq.size() > 0) begin
      k = srcq.pop_front();
      pulse(k);
      chk("source wake", 8'h00, 8'(pwr));
      wait_on("restart", 0, 6 * T - 5, 8 * T + 5);
    end
    // An I/O access outside the selected block must not wake the system.
    wr(6, sel % 15 + 1);
    pulse(6);
    chk("io block miss", 8'h01, 8'(cpu_slow));
    wr(5, 0);
    pulse(0);
    chk("suspend events", 8'h01, 8'(cpu_slow));
    pulse(8);
    chk("refresh always", 8'h00, 8'(pwr));
    wr(1, 0);
    repeat (20 * T) @(posedge core_clk);
    chk("timer off", 8'h00, 8'(pwr));
    pulse(3);
    wr(3, 1);
    wait_on("disk off", 2, 59 * T - 5, 61 * T + 5);
    pulse(3);
    chk("disk on", 8'h00, 8'(hdd_power_off));
    tally_and_finish();
  end
endmodule
